// File: logic/ref_select_defines.vh
// Constants for the reference input selector.
// Included by the selector module; holds definitions only.
`ifndef REF_SELECT_DEFINES_VH
`define REF_SELECT_DEFINES_VH

// Selection mode encodings
`define MODE_MANUAL      2'h0
`define MODE_AUTO        2'h1
`define MODE_SHORT_HOLD  2'h2
`define MODE_AUTO_HOLD   2'h3
`define MODE_AUTO_BIT    0

// Manual input choice encodings
`define CHOICE_CLK0      2'h0
`define CHOICE_CLK1      2'h1
`define CHOICE_CLK2      2'h2
`define CHOICE_CLK3      2'h3

// Reset values
`define MODE_RESET       2'h0
`define CHOICE_RESET     2'h0
`define PRIO_RESET       8'he4

// Per-input fields
`define NUM_INPUTS       4
`define PRIO_WIDTH       2
`define PRIO_LOWEST      2'h0
`define PRIO_MSB         7

// One-hot selector state codes
`define STATE_MANUAL     3'h1
`define STATE_TRACK      3'h2
`define STATE_HOLD       3'h4

// Output reset values and one-hot base
`define ACTIVE_RESET     2'h0
`define REF_SEL_RESET    4'h1
`define REF_ONE_HOT_BASE 4'h1
`define LOST_RESET       1'h0

`endif

// File: logic/reference_input_selector.v
// Reference input selector for the first-stage jitter cleaner loop.
// Assumes signal-loss flags and configuration arrive synchronous to sys_clk,
// and that cfgWrite loads all three configuration fields together.

`timescale 1ns/1ps
`default_nettype none

`include "ref_select_defines.vh"

module reference_input_selector (
  input  wire       sys_clk,
  input  wire       nrst,
  input  wire       cfgWrite,
  input  wire [1:0] refSelectModeIn,
  input  wire [1:0] manualChoiceIn,
  input  wire [7:0] inputPriorityLevelIn,
  input  wire [3:0] signalLossFlag,
  output reg  [1:0] refSelectMode,
  output reg  [1:0] manualChoice,
  output reg  [7:0] inputPriorityLevel,
  output reg  [1:0] activeInput,
  output reg  [3:0] jitterCleanerLoopRefSel,
  output reg        allInputsLost
);

  // ----------------------------------------------------------------
  // State codes
  // ----------------------------------------------------------------
  // Manual routing, automatic tracking, automatic hold with all lost.
  localparam [2:0] ST_MANUAL = `STATE_MANUAL;
  localparam [2:0] ST_TRACK  = `STATE_TRACK;
  localparam [2:0] ST_HOLD   = `STATE_HOLD;

  // ----------------------------------------------------------------
  // Internal signals
  // ----------------------------------------------------------------
  wire [1:0] prio [0:3];
  wire [3:0] inputUsable;
  wire       autoMode;
  reg  [1:0] autoPick;
  reg  [1:0] bestPrio;
  reg        anyValid;
  reg  [2:0] state;
  reg  [2:0] next_state;
  reg  [1:0] next_activeInput;
  integer    i;
  genvar     g;

  // ----------------------------------------------------------------
  // Configuration fields
  // ----------------------------------------------------------------
  // Priority byte packs input 0 in bits 7:6 down to input 3 in bits 1:0.
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      refSelectMode <= `MODE_RESET;
    end else if (cfgWrite) begin
      refSelectMode <= refSelectModeIn;
    end
  end

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      manualChoice <= `CHOICE_RESET;
    end else if (cfgWrite) begin
      manualChoice <= manualChoiceIn;
    end
  end

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      inputPriorityLevel <= `PRIO_RESET;
    end else if (cfgWrite) begin
      inputPriorityLevel <= inputPriorityLevelIn;
    end
  end

  // Only the low mode bit matters here; the holdover variants share routing.
  assign autoMode = refSelectMode[`MODE_AUTO_BIT];

  // ----------------------------------------------------------------
  // Per-input qualification
  // ----------------------------------------------------------------
  generate
    for (g = 0; g < `NUM_INPUTS; g = g + 1) begin : gInput
      assign prio[g] =
        inputPriorityLevel[`PRIO_MSB - `PRIO_WIDTH * g -: `PRIO_WIDTH];
      assign inputUsable[g] = ~signalLossFlag[g];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Automatic pick
  // ----------------------------------------------------------------
  // Scan from the last input down with >=, so the lowest index wins ties.
  always @* begin
    autoPick = `CHOICE_CLK0;
    bestPrio = `PRIO_LOWEST;
    anyValid = 1'b0;
    for (i = `NUM_INPUTS - 1; i >= 0; i = i - 1) begin
      if (inputUsable[i] &&
          (!anyValid || prio[i] >= bestPrio)) begin
        autoPick = i[1:0];
        bestPrio = prio[i];
        anyValid = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Selector state machine
  // ----------------------------------------------------------------
  // Re-evaluated every cycle, so automatic mode tracks the best usable
  // input while any is usable; revertive and hold-off timing are not modelled.
  always @* begin
    next_state = ST_MANUAL;
    case (state)
      ST_MANUAL: begin
        if (autoMode && anyValid)
          next_state = ST_TRACK;
        else if (autoMode)
          next_state = ST_HOLD;
        else
          next_state = ST_MANUAL;
      end
      ST_TRACK: begin
        if (!autoMode)
          next_state = ST_MANUAL;
        else if (!anyValid)
          next_state = ST_HOLD;
        else
          next_state = ST_TRACK;
      end
      ST_HOLD: begin
        if (!autoMode)
          next_state = ST_MANUAL;
        else if (anyValid)
          next_state = ST_TRACK;
        else
          next_state = ST_HOLD;
      end
      default: begin
        next_state = ST_MANUAL;
      end
    endcase
  end

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_MANUAL;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Reference choice
  // ----------------------------------------------------------------
  // With every input lost, automatic mode keeps the last reference, which
  // lets the loop ride on its oscillator instead of hopping to a dead input.
  always @* begin
    next_activeInput = activeInput;
    case (next_state)
      ST_MANUAL: begin
        next_activeInput = manualChoice;
      end
      ST_TRACK: begin
        next_activeInput = autoPick;
      end
      ST_HOLD: begin
        next_activeInput = activeInput;
      end
      default: begin
        next_activeInput = `CHOICE_CLK0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      activeInput <= `ACTIVE_RESET;
    end else begin
      activeInput <= next_activeInput;
    end
  end

  // Decoded from the next index so select and index move on one edge.
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      jitterCleanerLoopRefSel <= `REF_SEL_RESET;
    end else begin
      jitterCleanerLoopRefSel <= `REF_ONE_HOT_BASE << next_activeInput;
    end
  end

  // Reported in every mode, though only automatic mode acts on it.
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      allInputsLost <= `LOST_RESET;
    end else begin
      allInputsLost <= ~anyValid;
    end
  end

endmodule

`default_nettype wire

// File: testbench/ref_select_chk.sv
// Port checker for the reference input selector.
// Assumes one clock domain and bind from the bench top.
`timescale 1ns/1ps
`default_nettype none
module ref_select_chk (
  input wire       sys_clk,
  input wire       nrst,
  input wire [1:0] refSelectMode,
  input wire [1:0] manualChoice,
  input wire [7:0] inputPriorityLevel,
  input wire [3:0] signalLossFlag,
  input wire [1:0] activeInput,
  input wire [3:0] jitterCleanerLoopRefSel,
  input wire       allInputsLost
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  manual_route_a: assert property (!refSelectMode[0] |=>
    activeInput == $past(manualChoice)) else $error("manual route wrong");
  all_lost_a: assert property (refSelectMode[0] && &signalLossFlag
    |=> $stable(activeInput) && allInputsLost) else $error("lost hold");
  choice_ignored_a: assert property (refSelectMode[0] &&
    signalLossFlag == 4'he |=> activeInput == 2'h0) else $error("auto pick");
  one_hot_a: assert property (jitterCleanerLoopRefSel ==
    (4'h1 << activeInput)) else $error("reference one-hot wrong");
  tie_order_a: assert property (refSelectMode[0] && inputPriorityLevel == 0
    && signalLossFlag == 4'h3 |=> activeInput == 2'h2) else $error("tie");
  reset_fields_a: assert property (disable iff (1'b0) !nrst |->
    refSelectMode == 2'h0 && manualChoice == 2'h0) else $error("reset");
endmodule
`default_nettype wire

// File: testbench/reference_input_selector_test.sv
// Self-checking bench for the reference input selector.
// Assumes the checker file is compiled before this one.
`timescale 1ns/1ps
`default_nettype none
module reference_input_selector_test;
  logic sys_clk = 0, nrst = 1, cfgWrite = 0;
  logic [1:0] modeIn = 0, choiceIn = 0, mode, choice, active;
  logic [7:0] prioOut;
  logic [3:0] refSel;
  logic allLost;
  logic [7:0] prioIn = 8'he4;
  logic [3:0] lossFlag = 0;
  int err_count = 0, checks = 0;
  reference_input_selector u_dut (.sys_clk(sys_clk), .nrst(nrst),
    .cfgWrite(cfgWrite), .refSelectModeIn(modeIn), .manualChoiceIn(choiceIn),
    .inputPriorityLevelIn(prioIn), .signalLossFlag(lossFlag),
    .refSelectMode(mode), .manualChoice(choice),
    .inputPriorityLevel(prioOut), .activeInput(active),
    .jitterCleanerLoopRefSel(refSel), .allInputsLost(allLost));
  initial forever #12.5 sys_clk = ~sys_clk;
  task automatic check(input string what, input [7:0] exp, got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apply(input [1:0] m, c, input [7:0] p, input [3:0] l);
    @(posedge sys_clk);
    {modeIn, choiceIn, prioIn, lossFlag} <= {m, c, p, l};
    cfgWrite <= 1'b1;
    @(posedge sys_clk);
    cfgWrite <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  task automatic test_manual;
    for (int i = 0; i < 8; i++) begin
      apply(i[2] ? 2'h2 : 2'h0, i[1:0], 8'he4, 4'h5);
      check("activeInput", i[1:0], active);
      check("jitterCleanerLoopRefSel", 4'h1 << i[1:0], refSel);
    end
  endtask
  task automatic test_reset;
    apply(2'h3, 2'h1, 8'h1b, 4'hf);
    check("activeInput", 2'h2, active);
    check("allInputsLost", 1'b1, allLost);
    @(posedge sys_clk);
    nrst <= 1'b0;
    @(posedge sys_clk);
    #1;
    check("refSelectMode", 2'h0, mode);
    check("manualChoice", 2'h0, choice);
    check("activeInput", 2'h0, active);
    check("allInputsLost", 1'b0, allLost);
    @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    #1;
    check("activeInput", 2'h0, active);
    check("allInputsLost", 1'b1, allLost);
    apply(2'h0, 2'h0, 8'he4, 4'h0);
    check("allInputsLost", 1'b0, allLost);
  endtask
  task automatic test_auto;
    apply(2'h1, 2'h3, 8'he4, 4'h0);
    check("activeInput", 2'h0, active);
    check("jitterCleanerLoopRefSel", 4'h1, refSel);
    apply(2'h3, 2'h0, 8'h1b, 4'h8);
    check("activeInput", 2'h2, active);
    check("inputPriorityLevel", 8'h1b, prioOut);
    check("refSelectMode", 2'h3, mode);
    check("jitterCleanerLoopRefSel", 4'h4, refSel);
    apply(2'h1, 2'h3, 8'h00, 4'h3);
    check("activeInput", 2'h2, active);
    apply(2'h1, 2'h0, 8'he4, 4'hf);
    check("activeInput", 2'h2, active);
    check("allInputsLost", 1'b1, allLost);
  endtask
  task automatic stop_test;
    $display("err_count %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #5;
    nrst <= 1'b0;
    repeat (20) @(posedge sys_clk);
    #1;
    check("refSelectMode", 2'h0, mode);
    check("manualChoice", 2'h0, choice);
    check("inputPriorityLevel", 8'he4, prioOut);
    check("jitterCleanerLoopRefSel", 4'h1, refSel);
    @(posedge sys_clk);
    nrst <= 1'b1;
    test_manual();
    test_auto();
    test_reset();
    stop_test();
  end
  initial begin
    #20us;
    err_count++;
    stop_test();
  end
endmodule
bind reference_input_selector ref_select_chk u_chk (.sys_clk, .nrst,
  .refSelectMode, .manualChoice, .inputPriorityLevel, .signalLossFlag,
  .activeInput, .jitterCleanerLoopRefSel, .allInputsLost);
`default_nettype wire
